//--- rtl/tsp_pin_cell.sv
// one shared bidirectional pin: latch/direction/peripheral muxing
// assumes pin inputs are synchronous to clk_i
`timescale 1ns/1ps
module tsp_pin_cell
  import tsp_pkg::*;
(
  input  wire logic latch_i,
  input  wire logic dir_i,
  input  wire logic per_own_i,
  input  wire logic per_oe_i,
  input  wire logic per_out_i,
  input  wire logic pin_in_i,
  output logic      pin_o,
  output logic      pin_oe_o,
  output logic      rd_o
);

  // -----------------------------------------------------------------
  // drive and read-back
  // -----------------------------------------------------------------
  always_comb begin
    pin_oe_o = per_own_i ? per_oe_i : dir_i;
    pin_o    = per_own_i ? per_out_i : latch_i;
    rd_o     = dir_i ? latch_i : pin_in_i;
  end

endmodule : tsp_pin_cell

//--- rtl/tsp_pkg.sv
// package for the two-port shared gpio block
// assumes a 32-bit classic wishbone register bus, byte addressing
package tsp_pkg;

  // ---------------------------------------------------------------
  // register map (index times four gives the byte address)
  // ---------------------------------------------------------------
  localparam logic [7:0] TIMER_PORT_DATA_IDX  = 8'h03;
  localparam logic [7:0] SERIAL_PORT_DATA_IDX = 8'h08;
  localparam logic [7:0] TIMER_PORT_DIR_IDX   = 8'h07;
  localparam logic [7:0] SERIAL_PORT_DIR_IDX  = 8'h0C;
  localparam logic [7:0] SHARE_CTRL_IDX       = 8'h10;
  localparam int         ADDR_W               = 8;
  localparam int         PORT_W               = 2;

  // ---------------------------------------------------------------
  // share control field positions
  // ---------------------------------------------------------------
  localparam int CTRL_CH0_SEL_LO = 0;
  localparam int CTRL_CH0_SEL_HI = 1;
  localparam int CTRL_CH1_SEL_LO = 2;
  localparam int CTRL_CH1_SEL_HI = 3;
  localparam int CTRL_SER_EN     = 4;
  localparam int CTRL_W          = 5;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]  DIR_RST  = 2'h0;
  localparam logic [4:0]  CTRL_RST = 5'h00;
  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

  localparam int SER_TX_PIN = 0;
  localparam int SER_RX_PIN = 1;

  typedef enum logic [1:0] {
    TSP_IDLE,
    TSP_ACK
  } tsp_bus_t;

endpackage : tsp_pkg

//--- rtl/tsp_ports.sv
// two 2-bit shared gpio ports behind a classic wishbone slave
// assumes timer and serial units sit outside and drive the share ports
//
// Summary of operation
// - timer port has a software read/write latch for each of two pins
// - timer port direction 1 drives latch onto pin, 0 leaves pin input
// - reset clears timer port direction bits, all pins inputs
// - timer port read gives latch where direction 1, pin level where 0
// - data writes always update latches regardless of direction
// - timer channel selection takes pin direction; direction bit still picks read
// - serial port latches are read/write and untouched by reset
// - serial port direction 1 enables driver, 0 leaves pin input
// - reset clears serial port direction bits
// - serial port read gives latch where direction 1, pin where 0
// - serial enable gives pin 1 to receive, pin 0 to transmit
// - serial-owned pins ignore direction bit except for read source
// - clearing serial enable releases both serial pins at once
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
module tsp_ports
  import tsp_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [31:0]        wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic [PORT_W-1:0]  timer_pin_i,
  output logic      [PORT_W-1:0]  timer_pin_o,
  output logic      [PORT_W-1:0]  timer_pin_oe_o,
  input  wire logic [PORT_W-1:0]  timer_chan_oe_i,
  input  wire logic [PORT_W-1:0]  timer_chan_out_i,
  output logic      [PORT_W-1:0]  timer_chan_in_o,
  input  wire logic [PORT_W-1:0]  serial_pin_i,
  output logic      [PORT_W-1:0]  serial_pin_o,
  output logic      [PORT_W-1:0]  serial_pin_oe_o,
  input  wire logic               serial_tx_i,
  output logic                    serial_rx_o,
  output logic                    serial_enable_o
);

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [PORT_W-1:0] timer_port_latch_q;
  logic [PORT_W-1:0] timer_port_dir_q;
  logic [PORT_W-1:0] serial_port_latch_q;
  logic [PORT_W-1:0] serial_port_dir_q;
  logic [CTRL_W-1:0] share_ctrl_q;
  logic [PORT_W-1:0] timer_rd;
  logic [PORT_W-1:0] serial_rd;
  logic [PORT_W-1:0] timer_own;
  logic [PORT_W-1:0] serial_own;
  logic [PORT_W-1:0] serial_per_oe;
  logic [PORT_W-1:0] serial_per_out;
  logic              take;
  logic              wr_en;
  logic [ADDR_W-1:0] idx;
  logic              serial_enable;

  tsp_wb_slave u_bus (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cyc_i  (wb_cyc_i),
    .stb_i  (wb_stb_i),
    .ack_o  (wb_ack_o),
    .take_o (take)
  );

  assign idx   = wb_adr_i[ADDR_W+1:2];
  assign wr_en = take && wb_we_i && wb_sel_i[0] && (wb_adr_i[31:ADDR_W+2] == '0);

  // -----------------------------------------------------------------
  // data latches, no reset so contents survive it
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (wr_en && idx == TIMER_PORT_DATA_IDX) begin
      timer_port_latch_q <= wb_dat_i[PORT_W-1:0];
    end
    if (wr_en && idx == SERIAL_PORT_DATA_IDX) begin
      serial_port_latch_q <= wb_dat_i[PORT_W-1:0];
    end
  end

  // -----------------------------------------------------------------
  // direction and share control
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_port_dir_q  <= DIR_RST;
      serial_port_dir_q <= DIR_RST;
      share_ctrl_q      <= CTRL_RST;
    end else if (wr_en) begin
      if (idx == TIMER_PORT_DIR_IDX)  timer_port_dir_q  <= wb_dat_i[PORT_W-1:0];
      if (idx == SERIAL_PORT_DIR_IDX) serial_port_dir_q <= wb_dat_i[PORT_W-1:0];
      if (idx == SHARE_CTRL_IDX)      share_ctrl_q      <= wb_dat_i[CTRL_W-1:0];
    end
  end

  // -----------------------------------------------------------------
  // pin ownership; combinational so release is immediate
  // -----------------------------------------------------------------
  assign serial_enable = share_ctrl_q[CTRL_SER_EN];
  assign timer_own[0]  = share_ctrl_q[CTRL_CH0_SEL_HI] | share_ctrl_q[CTRL_CH0_SEL_LO];
  assign timer_own[1]  = share_ctrl_q[CTRL_CH1_SEL_HI] | share_ctrl_q[CTRL_CH1_SEL_LO];
  assign serial_own    = {PORT_W{serial_enable}};
  assign serial_per_oe = 2'b01;
  assign serial_per_out = {1'b0, serial_tx_i};
  assign serial_enable_o = serial_enable;
  assign serial_rx_o   = serial_enable ? serial_pin_i[SER_RX_PIN] : 1'b1;
  assign timer_chan_in_o = timer_pin_i;

  genvar g;
  generate
    for (g = 0; g < PORT_W; g++) begin : g_pin
      tsp_pin_cell u_timer (
        .latch_i   (timer_port_latch_q[g]),
        .dir_i     (timer_port_dir_q[g]),
        .per_own_i (timer_own[g]),
        .per_oe_i  (timer_chan_oe_i[g]),
        .per_out_i (timer_chan_out_i[g]),
        .pin_in_i  (timer_pin_i[g]),
        .pin_o     (timer_pin_o[g]),
        .pin_oe_o  (timer_pin_oe_o[g]),
        .rd_o      (timer_rd[g])
      );
      tsp_pin_cell u_serial (
        .latch_i   (serial_port_latch_q[g]),
        .dir_i     (serial_port_dir_q[g]),
        .per_own_i (serial_own[g]),
        .per_oe_i  (serial_per_oe[g]),
        .per_out_i (serial_per_out[g]),
        .pin_in_i  (serial_pin_i[g]),
        .pin_o     (serial_pin_o[g]),
        .pin_oe_o  (serial_pin_oe_o[g]),
        .rd_o      (serial_rd[g])
      );
    end
  endgenerate

  // -----------------------------------------------------------------
  // read data, registered on the same edge that raises ack
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= RD_ZERO;
    end else begin
      wb_dat_o <= RD_ZERO;
      if (wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i[31:ADDR_W+2] == '0) begin
        case (idx)
          TIMER_PORT_DATA_IDX:  wb_dat_o[PORT_W-1:0] <= timer_rd;
          SERIAL_PORT_DATA_IDX: wb_dat_o[PORT_W-1:0] <= serial_rd;
          TIMER_PORT_DIR_IDX:   wb_dat_o[PORT_W-1:0] <= timer_port_dir_q;
          SERIAL_PORT_DIR_IDX:  wb_dat_o[PORT_W-1:0] <= serial_port_dir_q;
          SHARE_CTRL_IDX:       wb_dat_o[CTRL_W-1:0] <= share_ctrl_q;
          default:              wb_dat_o <= RD_ZERO;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  chk_timer_dir_reset: assert property (@(posedge clk_i)
    $past(rst_i) |-> timer_port_dir_q == DIR_RST) else $error("timer dir not cleared");
  chk_serial_dir_reset: assert property (@(posedge clk_i)
    $past(rst_i) |-> serial_port_dir_q == DIR_RST) else $error("serial dir not cleared");
  chk_timer_gpio_oe: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_own == '0 |-> timer_pin_oe_o == timer_port_dir_q) else $error("timer oe bad");
  chk_timer_chan_oe: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_own[0] |-> timer_pin_oe_o[0] == timer_chan_oe_i[0]) else $error("chan oe bad");
  chk_serial_release: assert property (@(posedge clk_i) disable iff (rst_i)
    !serial_enable |-> serial_pin_oe_o == serial_port_dir_q) else $error("no release");
  chk_serial_tx_own: assert property (@(posedge clk_i) disable iff (rst_i)
    serial_enable |-> serial_pin_oe_o[0] && serial_pin_o[0] == serial_tx_i
    && !serial_pin_oe_o[1]) else $error("serial own bad");
  chk_latch_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && idx == TIMER_PORT_DATA_IDX |=> timer_port_latch_q == $past(wb_dat_i[1:0]))
    else $error("latch write lost");
  chk_timer_read: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 32'h0000_000C
    |=> wb_ack_o && wb_dat_o[1:0] == $past(timer_rd) && wb_dat_o[31:2] == '0)
    else $error("timer read bad");
  chk_serial_read: assert property (@(posedge clk_i) disable iff (rst_i)
    serial_port_dir_q == 2'b00 |-> serial_rd == serial_pin_i) else $error("pin read bad");

endmodule : tsp_ports

//--- rtl/tsp_wb_slave.sv
// classic wishbone slave handshake, one wait state then ack
// assumes a master that holds the request until ack
`timescale 1ns/1ps
module tsp_wb_slave
  import tsp_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic cyc_i,
  input  wire logic stb_i,
  output logic      ack_o,
  output logic      take_o
);

  tsp_bus_t state_q;

  // -----------------------------------------------------------------
  // ack one cycle after request, drop it in the next
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= TSP_IDLE;
    end else begin
      case (state_q)
        TSP_IDLE: if (cyc_i && stb_i) state_q <= TSP_ACK;
        TSP_ACK:  state_q <= TSP_IDLE;
        default:  state_q <= TSP_IDLE;
      endcase
    end
  end

  assign ack_o  = (state_q == TSP_ACK);
  assign take_o = ack_o && cyc_i && stb_i;

endmodule : tsp_wb_slave

//--- verif/tsp_far_model.sv
// far side of the shared pins: timer channels, serial unit, board
// assumes tb supplies board levels and the channel/transmit values
`timescale 1ns/1ps
module tsp_far_model (
  input  wire logic [1:0] t_drv_i,
  input  wire logic [1:0] t_oe_i,
  input  wire logic [1:0] s_drv_i,
  input  wire logic [1:0] s_oe_i,
  input  wire logic [1:0] ext_t_i,
  input  wire logic [1:0] ext_s_i,
  input  wire logic [1:0] cmp_val_i,
  input  wire logic       tx_val_i,
  output logic      [1:0] t_lvl_o,
  output logic      [1:0] s_lvl_o,
  output logic      [1:0] chan_oe_o,
  output logic      [1:0] chan_out_o,
  output logic            tx_o
);
  // ---------------------------------------------------------------
  // channel 0 drives (compare), channel 1 only listens (capture)
  // ---------------------------------------------------------------
  assign chan_oe_o  = 2'b01;
  assign chan_out_o = cmp_val_i;
  assign tx_o       = tx_val_i;
  // ---------------------------------------------------------------
  // wire level: design driver wins, else the board level
  // ---------------------------------------------------------------
  assign t_lvl_o = (t_oe_i & t_drv_i) | (~t_oe_i & ext_t_i);
  assign s_lvl_o = (s_oe_i & s_drv_i) | (~s_oe_i & ext_s_i);
endmodule : tsp_far_model

//--- verif/tsp_ports_tb.sv
// self-checking bench for the two shared gpio ports
// assumes tsp_pkg register map and one-wait-state wishbone slave
`timescale 1ns/1ps
module tsp_ports_tb;
  import tsp_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, tx = 0, stx, rx, sen;
  logic [31:0] adr = 0, dat = 0, rdat, wdo;
  logic [1:0]  tpi, tpo, toe, spi, spo, soe, cho, chv, own, lt, ls, dt, ds, lvt, lvs, oet, oes;
  logic [1:0]  ext_t = 0, ext_s = 0, tval = 0, tci;
  logic [4:0]  ctrl;
  int          fail_count = 0, checked = 0, cyc_n = 0;

  tsp_ports tsp_ports_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wdo),
    .wb_ack_o(ack), .timer_pin_i(tpi), .timer_pin_o(tpo), .timer_pin_oe_o(toe),
    .timer_chan_oe_i(cho), .timer_chan_out_i(chv), .timer_chan_in_o(tci), .serial_pin_i(spi),
    .serial_pin_o(spo), .serial_pin_oe_o(soe), .serial_tx_i(stx), .serial_rx_o(rx),
    .serial_enable_o(sen));
  tsp_far_model tsp_far_model_inst (.t_drv_i(tpo), .t_oe_i(toe), .s_drv_i(spo),
    .s_oe_i(soe), .ext_t_i(ext_t), .ext_s_i(ext_s), .cmp_val_i(tval), .tx_val_i(tx),
    .t_lvl_o(tpi), .s_lvl_o(spi), .chan_oe_o(cho), .chan_out_o(chv), .tx_o(stx));

  // ---------------------------------------------------------------
  // clock, watchdog, helpers
  // ---------------------------------------------------------------
  initial forever #2 clk_i = ~clk_i;
  initial forever begin
    @(posedge clk_i);
    cyc_n++;
    if (cyc_n > 20000) begin
      fail_count++;
      end_sim();
    end
  end

  task end_sim;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t value %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // single classic cycle; read data taken at the ack edge only
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {22'h00_0000, a, 2'b00};
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  function automatic logic [1:0] rdv(logic [1:0] d, logic [1:0] l, logic [1:0] p);
    return (d & l) | (~d & p);
  endfunction : rdv

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(16297));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      {lt, ls, dt, ds} = 8'($urandom);
      ctrl = (i == 0) ? 5'h1F : 5'($urandom);
      ext_t <= 2'($urandom);
      ext_s <= 2'($urandom);
      tval  <= 2'($urandom);
      tx    <= 1'($urandom);
      wb(1'b1, TIMER_PORT_DATA_IDX, {30'h0, lt});
      wb(1'b1, SERIAL_PORT_DATA_IDX, {30'h0, ls});
      wb(1'b1, TIMER_PORT_DIR_IDX, {30'h0, dt});
      wb(1'b1, SERIAL_PORT_DIR_IDX, {30'h0, ds});
      wb(1'b1, SHARE_CTRL_IDX, {27'h0, ctrl});
      @(posedge clk_i);
      #1;
      own = {ctrl[3] | ctrl[2], ctrl[1] | ctrl[0]};
      oet = (own & 2'b01) | (~own & dt);
      lvt = rdv(oet, (own & tval) | (~own & lt), ext_t);
      oes = ctrl[4] ? 2'b01 : ds;
      lvs = rdv(oes, ctrl[4] ? {ls[1], tx} : ls, ext_s);
      chk(toe, oet);
      chk(tpi, lvt);
      chk(tci, lvt);
      chk(soe, oes);
      chk(spi, lvs);
      chk(rx, ctrl[4] ? lvs[1] : 1'b1);
      chk(sen, ctrl[4]);
      wb(1'b0, TIMER_PORT_DATA_IDX, 32'h0);
      chk(rdat, {30'h0, rdv(dt, lt, lvt)});
      wb(1'b0, SERIAL_PORT_DATA_IDX, 32'h0);
      chk(rdat, {30'h0, rdv(ds, ls, lvs)});
      wb(1'b0, TIMER_PORT_DIR_IDX, 32'h0);
      chk(rdat, {30'h0, dt});
      wb(1'b0, SERIAL_PORT_DIR_IDX, 32'h0);
      chk(rdat, {30'h0, ds});
      wb(1'b0, 8'h11, 32'h0);
      chk(rdat, RD_ZERO);
    end
    $display("random sharing test done");
    // mid-run reset: directions clear, serial latches survive
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk(toe, 2'b00);
    chk(soe, 2'b00);
    wb(1'b0, TIMER_PORT_DIR_IDX, 32'h0);
    chk(rdat, RD_ZERO);
    wb(1'b0, SERIAL_PORT_DIR_IDX, 32'h0);
    chk(rdat, RD_ZERO);
    wb(1'b1, SERIAL_PORT_DIR_IDX, 32'h3);
    wb(1'b0, SERIAL_PORT_DATA_IDX, 32'h0);
    chk(rdat, {30'h0, ls});
    $display("reset test done");
    end_sim();
  end
endmodule : tsp_ports_tb
